// file: logic/dbd_block_done.sv
// Purpose: Per-channel block-completion flags with write-one-to-clear and interrupt mask.
// Assumes: Completion pulses come from logic on ref_clk; APB slave inserts one wait state.
// Notes:   A completion and a clearing write in the same cycle leave the flag set.
//
// Summary of operation
// (R1) One flag per channel, channel N bit N.
// (R2) Completion sets flag; it stays until cleared.
// (R3) Read returns one once transfer has completed.
// (R4) Flags reset to zero; write one clears.
// (R5) Mask bit zero blocks interrupt; one passes it.
// (R6) Write zero keeps flag; set beats clear.
`timescale 1ns/1ps
module dbd_block_done
  import dbd_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire dbd_apb_req_t       apb_req,
  output dbd_apb_rsp_t            apb_rsp,
  input  wire logic [NUM_CHAN-1:0] chan_block_done,
  output logic [NUM_CHAN-1:0]     chan_block_done_flag,
  output logic                    block_done_irq
);

  dbd_state_t s_q;
  dbd_state_t s_d;

  logic        access;
  logic        wr_en;
  logic        rd_en;
  logic        hit_status;
  logic        hit_mask;
  logic [31:0] clr_bits;
  logic        ready_q;

  always_comb
  begin
    access     = apb_req.psel && apb_req.penable;
    // Writes land only at the edge where pready is sampled high, so a clear is applied once;
    // a completion in that same cycle survives it, one that arrived during the wait state is cleared.
    wr_en      = access && apb_req.pwrite && ready_q;
    rd_en      = access && !apb_req.pwrite;
    hit_status = (apb_req.paddr == STATUS_OFFSET);
    hit_mask   = (apb_req.paddr == MASK_OFFSET);
    clr_bits   = (wr_en && hit_status) ? apb_req.pwdata : READ_ZERO;

    s_d = s_q;
    // A new completion is ORed in after the clear so it is never lost.
    s_d.status = (s_q.status & ~clr_bits) | chan_block_done; // [R1] [R2] [R4] [R6]
    if (wr_en && hit_mask)
    begin
      s_d.mask = apb_req.pwdata;
    end
    if (rd_en)
    begin
      if (hit_status)
      begin
        s_d.rdata = s_q.status; // [R3]
      end
      else if (hit_mask)
      begin
        s_d.rdata = s_q.mask;
      end
      else
      begin
        s_d.rdata = READ_ZERO;
      end
    end
    s_d.slverr = access && !hit_status && !hit_mask;
    s_d.irq    = |(s_d.status & s_d.mask); // [R5]

    if (rst)
    begin
      s_d.status = STATUS_RESET; // [R4]
      s_d.mask   = MASK_RESET; // [R5]
      s_d.rdata  = READ_ZERO;
      s_d.slverr = 1'b0;
      s_d.irq    = 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    s_q <= s_d;
  end

  // Read data is registered, so the access phase takes one wait cycle: pready rises when
  // the registered answer is valid, two cycles after setup.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ready_q <= 1'b0;
    end
    else
    begin
      ready_q <= apb_req.psel && apb_req.penable && !ready_q;
    end
  end

  always_comb
  begin
    apb_rsp.pready  = ready_q;
    apb_rsp.pslverr = ready_q && s_q.slverr;
    apb_rsp.prdata  = s_q.rdata;
  end

  assign chan_block_done_flag = s_q.status;
  assign block_done_irq       = s_q.irq;

endmodule

// file: shared/dbd_pkg.sv
// Purpose: Constants and carrier types for the DMA block-done status block.
// Assumes: 32-bit APB, one clock, synchronous active-high reset.
// Notes:   Register offsets are byte addresses.
package dbd_pkg;

  localparam int unsigned NUM_CHAN = 32;

  localparam logic [11:0] MASK_OFFSET   = 12'h0000;
  localparam logic [11:0] STATUS_OFFSET = 12'h0004;

  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET   = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO    = 32'h0000_0000;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } dbd_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } dbd_apb_rsp_t;

  typedef struct packed {
    logic [31:0] status;
    logic [31:0] mask;
    logic [31:0] rdata;
    logic        slverr;
    logic        irq;
  } dbd_state_t;

endpackage

// file: verification/dbd_dma_eng.sv
// Purpose: DMA engines. Assumes: one clock. Notes: none.
`timescale 1ns/1ps
module dbd_dma_eng (input logic ref_clk, input logic [31:0] go, output logic [31:0] done);
  always_ff @(posedge ref_clk) done <= go;
endmodule

// file: verification/dbd_block_done_assertions.sv
// Purpose: checks. Assumes: one clock. Notes: none.
`timescale 1ns/1ps
module dbd_chk import dbd_pkg::*; (input logic ref_clk, rst, block_done_irq,
input logic [31:0] chan_block_done, chan_block_done_flag, input dbd_apb_req_t apb_req,
input dbd_apb_rsp_t apb_rsp);
wire [31:0] f = chan_block_done_flag;
default clocking @(posedge ref_clk); endclocking
default disable iff (rst);
a_flag_set: assert property (1 |=> &(f | ~$past(chan_block_done))) else $error("set");
a_flag_hold: assert property (!apb_req.pwrite |=> &(f | ~$past(f))) else $error("lost");
a_irq_src: assert property (block_done_irq |-> |f) else $error("irq");
a_ready_wait: assert property (apb_req.psel && apb_req.penable && !apb_rsp.pready
  |=> apb_rsp.pready) else $error("no ready");
a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready) else $error("ready");
a_flag_clear: assert property (apb_rsp.pready && apb_req.psel && apb_req.penable
  && apb_req.pwrite && apb_req.paddr == STATUS_OFFSET
  |=> ((f & $past(apb_req.pwdata) & ~$past(chan_block_done)) == 32'h0000_0000))
  else $error("clear");
cover property (apb_req.pwrite && apb_rsp.pready);
cover property (block_done_irq);
cover property (|f);
endmodule
bind dbd_block_done dbd_chk u_chk (.*);

// file: verification/tb_dma_block_done_status.sv
// Purpose: bench. Assumes: 20 MHz. Notes: none.
`timescale 1ns/1ps
`define CK(a,b) begin tests_run++; if ((a)!==(b)) begin fail_count++; $display("ERROR %0t %h %h",$time,a,b); end end
module tb_dma_block_done_status import dbd_pkg::*;;
logic ref_clk=0, rst=1, block_done_irq; logic [31:0] go=0, chan_block_done, chan_block_done_flag;
dbd_apb_req_t apb_req=0; dbd_apb_rsp_t apb_rsp; int fail_count, tests_run;
always #25 ref_clk=~ref_clk;
dbd_dma_eng eng(.ref_clk, .go, .done(chan_block_done));
dbd_block_done dut(.*);
task complete_run; if (fail_count==0 && tests_run>0) $display("TEST PASSED");
else $display("TEST FAILED"); $finish; endtask
int cyc = 0;
logic [31:0] rd;
logic        er;
// The whole run takes under a hundred cycles; this ceiling only catches a hang.
always @(posedge ref_clk)
begin
  cyc <= cyc + 1;
  if (cyc == 3000)
  begin
    fail_count++;
    complete_run;
  end
end
// Holds the request until pready is seen high, takes the answer in that cycle.
task bus(input logic w, input logic [11:0] a, input logic [31:0] d,
         output logic [31:0] r, output logic e);
  @(posedge ref_clk) apb_req <= {2'b10, w, a, d};
  @(posedge ref_clk) apb_req.penable <= 1'b1;
  do @(negedge ref_clk); while (apb_rsp.pready !== 1'b1);
  r = apb_rsp.prdata;
  e = apb_rsp.pslverr;
  @(posedge ref_clk) apb_req <= '0;
endtask
task t_reset;
  `CK(chan_block_done_flag, STATUS_RESET)
  `CK(block_done_irq, 1'b0)
  bus(1'b0, MASK_OFFSET, '0, rd, er);
  `CK(rd, MASK_RESET)
  `CK(er, 1'b0)
endtask
task t_set;
  go <= 32'hA5A5_0001;
  @(posedge ref_clk) go <= '0;
  repeat (2) @(posedge ref_clk);
  bus(1'b0, STATUS_OFFSET, '0, rd, er);
  `CK(rd, 32'hA5A5_0001)
  bus(1'b1, STATUS_OFFSET, 32'h0000_0001, rd, er);
  @(negedge ref_clk);
  `CK(chan_block_done_flag, 32'hA5A5_0000)
  `CK(block_done_irq, 1'b0)
endtask
task t_irq;
  bus(1'b1, MASK_OFFSET, 32'h8000_0000, rd, er);
  @(negedge ref_clk);
  `CK(block_done_irq, 1'b1)
  bus(1'b0, MASK_OFFSET, '0, rd, er);
  `CK(rd, 32'h8000_0000)
endtask
// Completion of channel 9 lands on the same edge as the write that clears it.
task t_race;
  fork
    bus(1'b1, STATUS_OFFSET, 32'h8000_0200, rd, er);
    begin
      repeat (2) @(posedge ref_clk);
      go <= 32'h0000_0200;
      @(posedge ref_clk) go <= '0;
    end
  join
  @(negedge ref_clk);
  `CK(chan_block_done_flag, 32'h25A5_0200)
  `CK(block_done_irq, 1'b0)
endtask
task t_unmapped;
  bus(1'b0, 12'h008, '0, rd, er);
  `CK(er, 1'b1)
  `CK(rd, READ_ZERO)
endtask
initial
begin
  repeat (10) @(posedge ref_clk);
  rst <= 1'b0;
  t_reset;
  t_set;
  t_irq;
  t_race;
  t_unmapped;
  complete_run;
end
endmodule
